// ---- common/icp_cfg.svh ----
`ifndef ICP_CFG_SVH
`define ICP_CFG_SVH

// Register indices; the byte address is four times the index
`define ICP_IDX_PRI_A      8'h19
`define ICP_IDX_PRI_B      8'h1A
`define ICP_IDX_PRI_BACKUP 8'h1C
`define ICP_IDX_CFG3       8'h22
`define ICP_IDX_CFG4       8'h23
`define ICP_IDX_CFG5       8'h24
`define ICP_IDX_CFG6       8'h25
`define ICP_IDX_CFG9       8'h28
`define ICP_IDX_AUX        8'h40
`define ICP_IDX_STATUS     8'h41

// Reset values
`define ICP_PRI_A_RST      8'h32
`define ICP_PRI_B_RST      8'h00
`define ICP_PRI_BACKUP_RST 8'h04
`define ICP_CFG_HI_RST     4'h0
`define ICP_CODE_RST_LOW   4'h0
`define ICP_CODE_RST_HIGH  4'h3
`define ICP_AUX_RST        2'h0

// Field positions of the input configuration registers
`define ICP_CFG_PROG_DIV_BIT 7
`define ICP_CFG_FIX8K_BIT    6
`define ICP_CFG_BUCKET_HI    5
`define ICP_CFG_BUCKET_LO    4
`define ICP_CFG_CODE_HI      3
`define ICP_CFG_CODE_LO      0

// Auxiliary control fields
`define ICP_AUX_TARGET_BIT 0
`define ICP_AUX_RATE_BIT   1

// Inputs with differential receivers, one bit per input (3,4,5,6,9)
`define ICP_DIFF_MASK      5'h0C

// Nominal rate codes with special handling
`define ICP_CODE_2K        4'h9
`define ICP_CODE_4K        4'hA
`define ICP_CODE_155M52    4'h8
`define ICP_CODE_31M25     4'hD
`define ICP_CODE_ALT_156M  4'h4

`endif

// ---- common/icp_pkg.sv ----
package icp_pkg;

  typedef enum logic [1:0] {
    ICP_MODE_DIRECT,
    ICP_MODE_FIXED8K,
    ICP_MODE_PROG,
    ICP_MODE_ALT
  } icp_mode_t;

  typedef enum logic [4:0] {
    ICP_RATE_8K,
    ICP_RATE_1544K,
    ICP_RATE_2048K,
    ICP_RATE_6M48,
    ICP_RATE_19M44,
    ICP_RATE_25M92,
    ICP_RATE_38M88,
    ICP_RATE_51M84,
    ICP_RATE_77M76,
    ICP_RATE_155M52,
    ICP_RATE_2K,
    ICP_RATE_4K,
    ICP_RATE_31M25,
    ICP_RATE_10M,
    ICP_RATE_25M,
    ICP_RATE_62M5,
    ICP_RATE_125M,
    ICP_RATE_156M25,
    ICP_RATE_UNDEF
  } icp_rate_t;

endpackage

// ---- common/icp_reg_if.sv ----
interface icp_reg_if;
  logic       wr_stb;
  logic [7:0] idx;
  logic [7:0] wdata;
  logic [7:0] rd_data;
  logic       hit;

  modport bus  (output wr_stb, output idx, output wdata, input rd_data, input hit);
  modport regs (input wr_stb, input idx, input wdata, output rd_data, output hit);
endinterface

// ---- src/icp_rate_decode.sv ----
`include "icp_cfg.svh"

module icp_rate_decode
  import icp_pkg::*;
(
  input  wire logic       prog_div_i,
  input  wire logic       fix8k_i,
  input  wire logic [3:0] code_i,
  input  wire logic       rate_sel_i,
  input  wire logic       diff_i,
  output icp_mode_t       mode_o,
  output icp_rate_t       rate_o,
  output logic            valid_o
);

  // Predivider mode; 2k/4k codes cannot use the 8 kHz predivider
  always_comb begin
    if (prog_div_i && fix8k_i) begin
      mode_o = ICP_MODE_ALT;
    end else if (prog_div_i) begin
      mode_o = ICP_MODE_PROG;
    end else if (fix8k_i && code_i != `ICP_CODE_2K && code_i != `ICP_CODE_4K) begin
      mode_o = ICP_MODE_FIXED8K;
    end else begin
      mode_o = ICP_MODE_DIRECT;
    end
  end

  // Nominal rate and whether the code is legal for this input
  always_comb begin
    rate_o  = ICP_RATE_UNDEF;
    valid_o = 1'b1;
    if (prog_div_i && fix8k_i) begin
      case (code_i)
        4'h0: rate_o = ICP_RATE_10M;
        4'h1: rate_o = ICP_RATE_25M;
        4'h2: rate_o = ICP_RATE_62M5;
        4'h3: rate_o = ICP_RATE_125M;
        `ICP_CODE_ALT_156M: begin
          rate_o  = ICP_RATE_156M25;
          valid_o = diff_i;
        end
        default: valid_o = 1'b0;
      endcase
    end else begin
      case (code_i)
        4'h0: rate_o = ICP_RATE_8K;
        4'h1: rate_o = rate_sel_i ? ICP_RATE_2048K : ICP_RATE_1544K;
        4'h2: rate_o = ICP_RATE_6M48;
        4'h3: rate_o = ICP_RATE_19M44;
        4'h4: rate_o = ICP_RATE_25M92;
        4'h5: rate_o = ICP_RATE_38M88;
        4'h6: rate_o = ICP_RATE_51M84;
        4'h7: rate_o = ICP_RATE_77M76;
        `ICP_CODE_155M52: begin
          rate_o  = ICP_RATE_155M52;
          valid_o = diff_i;
        end
        `ICP_CODE_2K: rate_o = ICP_RATE_2K;
        `ICP_CODE_4K: rate_o = ICP_RATE_4K;
        `ICP_CODE_31M25: begin
          rate_o  = ICP_RATE_31M25;
          // Not a multiple of 8 kHz
          valid_o = !(fix8k_i && !prog_div_i);
        end
        default: valid_o = 1'b0;
      endcase
    end
  end

endmodule

// ---- src/icp_apb_slave.sv ----
module icp_apb_slave (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [9:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic [31:0]      prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  icp_reg_if.bus           rif
);

  logic        aligned;
  logic        mapped;
  logic [31:0] prdata_q;

  // Decode; a misaligned byte address is treated as unmapped
  assign aligned     = (paddr_i[1:0] == 2'h0);
  assign mapped      = aligned && rif.hit;
  assign rif.idx     = paddr_i[9:2];
  assign rif.wdata   = pwdata_i[7:0];
  assign rif.wr_stb  = psel_i && penable_i && pwrite_i && mapped;

  // Zero wait states: read data is captured in the setup cycle
  assign pready_o  = 1'b1;
  assign pslverr_o = psel_i && penable_i && !mapped;
  assign prdata_o  = prdata_q;

  // Read data register, upper bits always zero
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prdata_q <= 32'h0000_0000;
    end else if (psel_i && !penable_i && !pwrite_i) begin
      prdata_q <= mapped ? {24'h00_0000, rif.rd_data} : 32'h0000_0000;
    end
  end

endmodule

// ---- src/icp_regs.sv ----
// Overview of operation
// - Each input has a 4-bit priority; 0001 ranks highest, 1111 lowest.
// - Priority 0000 makes that input unavailable for selection.
// - Priorities feed the system DPLL only while target select is zero.
// - Nonzero write to input 4 priority clears input 6 priority.
// - Nonzero write to input 3 priority clears input 5 priority.
// - Programmable predivide alone divides the input by the shared factor.
// - Fixed 8 kHz alone applies a preset predivider giving 8 kHz.
// - Fixed 8 kHz is ignored for codes 1001 and 1010 without predivide.
// - Both predivide enables select the alternate frequency table.
// - A 2-bit field picks one of four leak profiles per input.
// - Standard codes 0000-0111 decode to 8 kHz up to 77.76 MHz.
// - Standard codes 1000-1111: 155.52M, 2k, 4k, 31.25M, rest undefined.
// - Alternate codes 0000-0100 decode 10M to 156.25M; rest undefined.
// - Rate code resets to 0000 for inputs 3,4 and 0011 for 5,6,9.
//
// Local design decision: the APB interface to the registers.
`include "icp_cfg.svh"

module icp_regs
  import icp_pkg::*;
(
  input  wire logic        CLK_I,
  input  wire logic        RST_N_I,
  input  wire logic        PSEL_I,
  input  wire logic        PENABLE_I,
  input  wire logic        PWRITE_I,
  input  wire logic [9:0]  PADDR_I,
  input  wire logic [31:0] PWDATA_I,
  output logic [31:0]      PRDATA_O,
  output logic             PREADY_O,
  output logic             PSLVERR_O,
  output logic [19:0]      PRIORITY_O,
  output logic [4:0]       AVAIL_O,
  output logic [9:0]       BUCKET_O,
  output logic [9:0]       PREDIV_MODE_O,
  output logic [24:0]      RATE_O,
  output logic [4:0]       RATE_VALID_O
);

  localparam int NUM_IN = 5;
  // Reset images of the priority words and the differential input map
  localparam logic [7:0] pri_a_rst  = `ICP_PRI_A_RST;
  localparam logic [7:0] pri_b_rst  = `ICP_PRI_B_RST;
  localparam logic [7:0] pri_bk_rst = `ICP_PRI_BACKUP_RST;
  localparam logic [4:0] diff_mask  = `ICP_DIFF_MASK;

  icp_reg_if rif ();

  // Inputs in slot order: 3, 4, 5, 6, 9
  logic [3:0] pri_q   [NUM_IN];
  logic [7:0] cfg_q   [NUM_IN];
  logic [1:0] aux_q;
  logic [3:0] pri_out_q [NUM_IN];
  logic [4:0] avail_q;
  logic [1:0] bucket_q  [NUM_IN];
  icp_mode_t  mode_q    [NUM_IN];
  icp_rate_t  rate_q    [NUM_IN];
  logic [4:0] valid_q;
  icp_mode_t  mode_w    [NUM_IN];
  icp_rate_t  rate_w    [NUM_IN];
  logic [4:0] valid_w;
  logic       target_sel;
  logic       rate_sel;
  logic       wr_a;
  logic       wr_b;
  logic       wr_bk;
  logic [3:0] wd_lo;
  logic [3:0] wd_hi;

  // Index of the configuration register of one input slot
  function automatic logic [7:0] cfg_index(input int k);
    case (k)
      0:       cfg_index = `ICP_IDX_CFG3;
      1:       cfg_index = `ICP_IDX_CFG4;
      2:       cfg_index = `ICP_IDX_CFG5;
      3:       cfg_index = `ICP_IDX_CFG6;
      default: cfg_index = `ICP_IDX_CFG9;
    endcase
  endfunction

  // Reset value of one configuration register
  function automatic logic [7:0] cfg_reset(input int k);
    cfg_reset = (k < 2) ? {`ICP_CFG_HI_RST, `ICP_CODE_RST_LOW}
                        : {`ICP_CFG_HI_RST, `ICP_CODE_RST_HIGH};
  endfunction

  icp_apb_slave u_apb (
    .clk_i     (CLK_I),
    .rst_n_i   (RST_N_I),
    .psel_i    (PSEL_I),
    .penable_i (PENABLE_I),
    .pwrite_i  (PWRITE_I),
    .paddr_i   (PADDR_I),
    .pwdata_i  (PWDATA_I),
    .prdata_o  (PRDATA_O),
    .pready_o  (PREADY_O),
    .pslverr_o (PSLVERR_O),
    .rif       (rif)
  );

  assign target_sel = aux_q[`ICP_AUX_TARGET_BIT];
  assign rate_sel   = aux_q[`ICP_AUX_RATE_BIT];
  assign wr_a       = rif.wr_stb && rif.idx == `ICP_IDX_PRI_A;
  assign wr_b       = rif.wr_stb && rif.idx == `ICP_IDX_PRI_B;
  assign wr_bk      = rif.wr_stb && rif.idx == `ICP_IDX_PRI_BACKUP;
  assign wd_lo      = rif.wdata[3:0];
  assign wd_hi      = rif.wdata[7:4];

  // Priority fields; pairing clears happen in the same write
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      pri_q[0] <= pri_a_rst[3:0];
      pri_q[1] <= pri_a_rst[7:4];
      pri_q[2] <= pri_b_rst[3:0];
      pri_q[3] <= pri_b_rst[7:4];
      pri_q[4] <= pri_bk_rst[3:0];
    end else begin
      if (wr_a) begin
        pri_q[0] <= wd_lo;
        pri_q[1] <= wd_hi;
        if (wd_hi != 4'h0) begin
          pri_q[3] <= 4'h0;
        end
        if (wd_lo != 4'h0) begin
          pri_q[2] <= 4'h0;
        end
      end
      if (wr_b) begin
        pri_q[2] <= wd_lo;
        pri_q[3] <= wd_hi;
      end
      if (wr_bk) begin
        pri_q[4] <= wd_lo;
      end
    end
  end

  // Per-input configuration registers
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      for (int k = 0; k < NUM_IN; k++) begin
        cfg_q[k] <= cfg_reset(k);
      end
    end else begin
      for (int k = 0; k < NUM_IN; k++) begin
        if (rif.wr_stb && rif.idx == cfg_index(k)) begin
          cfg_q[k] <= rif.wdata;
        end
      end
    end
  end

  // Target select and E1/T1 rate select
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      aux_q <= `ICP_AUX_RST;
    end else if (rif.wr_stb && rif.idx == `ICP_IDX_AUX) begin
      aux_q <= rif.wdata[1:0];
    end
  end

  // Read mux and address map
  always_comb begin
    rif.rd_data = 8'h00;
    rif.hit     = 1'b1;
    case (rif.idx)
      `ICP_IDX_PRI_A:      rif.rd_data = {pri_q[1], pri_q[0]};
      `ICP_IDX_PRI_B:      rif.rd_data = {pri_q[3], pri_q[2]};
      `ICP_IDX_PRI_BACKUP: rif.rd_data = {4'h0, pri_q[4]};
      `ICP_IDX_CFG3:       rif.rd_data = cfg_q[0];
      `ICP_IDX_CFG4:       rif.rd_data = cfg_q[1];
      `ICP_IDX_CFG5:       rif.rd_data = cfg_q[2];
      `ICP_IDX_CFG6:       rif.rd_data = cfg_q[3];
      `ICP_IDX_CFG9:       rif.rd_data = cfg_q[4];
      `ICP_IDX_AUX:        rif.rd_data = {6'h00, aux_q};
      // Live decode status, writes ignored
      `ICP_IDX_STATUS:     rif.rd_data = {3'h0, valid_q};
      default:             rif.hit     = 1'b0;
    endcase
  end

  // Rate decoders, one per input
  for (genvar k = 0; k < NUM_IN; k++) begin : g_dec
    icp_rate_decode u_dec (
      .prog_div_i (cfg_q[k][`ICP_CFG_PROG_DIV_BIT]),
      .fix8k_i    (cfg_q[k][`ICP_CFG_FIX8K_BIT]),
      .code_i     (cfg_q[k][`ICP_CFG_CODE_HI:`ICP_CFG_CODE_LO]),
      .rate_sel_i (rate_sel),
      .diff_i     (diff_mask[k]),
      .mode_o     (mode_w[k]),
      .rate_o     (rate_w[k]),
      .valid_o    (valid_w[k])
    );
    assign PRIORITY_O[4*k +: 4]    = pri_out_q[k];
    assign BUCKET_O[2*k +: 2]      = bucket_q[k];
    assign PREDIV_MODE_O[2*k +: 2] = mode_q[k];
    assign RATE_O[5*k +: 5]        = rate_q[k];
  end

  assign AVAIL_O      = avail_q;
  assign RATE_VALID_O = valid_q;

  // Outputs to the selector and monitors, registered for clean timing
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      avail_q <= 5'h00;
      valid_q <= 5'h00;
      for (int k = 0; k < NUM_IN; k++) begin
        pri_out_q[k] <= 4'h0;
        bucket_q[k]  <= 2'h0;
        mode_q[k]    <= ICP_MODE_DIRECT;
        rate_q[k]    <= ICP_RATE_8K;
      end
    end else begin
      valid_q <= valid_w;
      for (int k = 0; k < NUM_IN; k++) begin
        // Other DPLL owns the fields while target select is set
        pri_out_q[k] <= target_sel ? 4'h0 : pri_q[k];
        avail_q[k]   <= !target_sel && pri_q[k] != 4'h0;
        bucket_q[k]  <= cfg_q[k][`ICP_CFG_BUCKET_HI:`ICP_CFG_BUCKET_LO];
        mode_q[k]    <= mode_w[k];
        rate_q[k]    <= rate_w[k];
      end
    end
  end

  // Checks on slot 0 (input 3), input 4 availability, target select, the pairing clears and backup reads
  logic [3:0] pri0_w;
  logic [7:0] cfg0_w;
  assign pri0_w = pri_q[0];
  assign cfg0_w = cfg_q[0];

  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);

  sequence s_wr_hi_nz;
    wr_a && wd_hi != 4'h0;
  endsequence
  sequence s_wr_lo_nz;
    wr_a && wd_lo != 4'h0;
  endsequence

  property p_rank;
    !target_sel |=> PRIORITY_O[3:0] == $past(pri0_w);
  endproperty
  a_rank: assert property (p_rank) else $error("priority not passed through");

  property p_unavail;
    AVAIL_O[1] |-> PRIORITY_O[7:4] != 4'h0;
  endproperty
  a_unavail: assert property (p_unavail) else $error("zero priority shown available");

  property p_target;
    target_sel |=> PRIORITY_O == 20'h00000 && AVAIL_O == 5'h00;
  endproperty
  a_target: assert property (p_target) else $error("priority leaked to system DPLL");

  property p_clear6;
    s_wr_hi_nz |=> pri_q[3] == 4'h0 ##1 PRIORITY_O[15:12] == 4'h0;
  endproperty
  a_clear6: assert property (p_clear6) else $error("input 6 priority not cleared");

  property p_clear5;
    s_wr_lo_nz |=> pri_q[2] == 4'h0 ##1 !AVAIL_O[2];
  endproperty
  a_clear5: assert property (p_clear5) else $error("input 5 priority not cleared");

  property p_prog;
    cfg0_w[7:6] == 2'h2 |=> PREDIV_MODE_O[1:0] == ICP_MODE_PROG;
  endproperty
  a_prog: assert property (p_prog) else $error("programmable predivide not selected");

  property p_fixed;
    cfg0_w[7:6] == 2'h1 && cfg0_w[3:0] != `ICP_CODE_2K && cfg0_w[3:0] != `ICP_CODE_4K
      |=> PREDIV_MODE_O[1:0] == ICP_MODE_FIXED8K;
  endproperty
  a_fixed: assert property (p_fixed) else $error("fixed 8 kHz not selected");

  property p_ignore8k;
    cfg0_w[7:6] == 2'h1 && cfg0_w[3:0] == `ICP_CODE_2K |=> PREDIV_MODE_O[1:0] == ICP_MODE_DIRECT;
  endproperty
  a_ignore8k: assert property (p_ignore8k) else $error("fixed 8 kHz not ignored");

  property p_alt;
    cfg0_w[7:6] == 2'h3 && cfg0_w[3:0] == 4'h0 |=> RATE_O[4:0] == ICP_RATE_10M;
  endproperty
  a_alt: assert property (p_alt) else $error("alternate table not used");

  property p_bucket;
    ##1 BUCKET_O[1:0] == $past(cfg0_w[5:4]);
  endproperty
  a_bucket: assert property (p_bucket) else $error("leak profile select wrong");

  property p_std8k;
    cfg0_w[7] == 1'b0 && cfg0_w[3:0] == 4'h0 |=> RATE_O[4:0] == ICP_RATE_8K && RATE_VALID_O[0];
  endproperty
  a_std8k: assert property (p_std8k) else $error("code 0000 not 8 kHz");

  property p_31m_fixed;
    cfg0_w[7:6] == 2'h1 && cfg0_w[3:0] == `ICP_CODE_31M25 |=> !RATE_VALID_O[0];
  endproperty
  a_31m_fixed: assert property (p_31m_fixed) else $error("31.25 MHz accepted in 8k mode");

  property p_alt_undef;
    cfg0_w[7:6] == 2'h3 && cfg0_w[3:0] > 4'h4 |=> !RATE_VALID_O[0];
  endproperty
  a_alt_undef: assert property (p_alt_undef) else $error("undefined alternate code valid");

  property p_bk_rsvd;
    PSEL_I && PENABLE_I && !PWRITE_I && PADDR_I == {`ICP_IDX_PRI_BACKUP, 2'h0}
      |-> PRDATA_O[31:4] == 28'h0000000;
  endproperty
  a_bk_rsvd: assert property (p_bk_rsvd) else $error("reserved bits read nonzero");

endmodule

// ---- testbench/tb_input_clock_priority_config.sv ----
`include "icp_cfg.svh"

module tb_input_clock_priority_config
  import icp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed {
    logic        rd;
    logic [31:0] data;
    logic        err;
  } icp_tb_exp_t;

  logic        clk = 1'b0;
  logic        rst_n;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [9:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [19:0] prio;
  logic [4:0]  avail;
  logic [9:0]  bucket;
  logic [9:0]  pmode;
  logic [24:0] rate;
  logic [4:0]  rvalid;
  icp_tb_exp_t exp_q[$];
  int          error_cnt = 0;
  int          n_tests = 0;
  int          cyc = 0;

  // Free-running 100 MHz clock
  always #5 clk = ~clk;

  icp_regs dut (
    .CLK_I        (clk),
    .RST_N_I      (rst_n),
    .PSEL_I       (psel),
    .PENABLE_I    (penable),
    .PWRITE_I     (pwrite),
    .PADDR_I      (paddr),
    .PWDATA_I     (pwdata),
    .PRDATA_O     (prdata),
    .PREADY_O     (pready),
    .PSLVERR_O    (pslverr),
    .PRIORITY_O   (prio),
    .AVAIL_O      (avail),
    .BUCKET_O     (bucket),
    .PREDIV_MODE_O(pmode),
    .RATE_O       (rate),
    .RATE_VALID_O (rvalid)
  );

  task automatic fail(input string msg);
    error_cnt++;
    $display("[FAIL] %0t %s", $time, msg);
  endtask

  task automatic report_and_stop();
    $display("counts: %0d checks, %0d mismatches", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Bus result compare, oldest note first
  task automatic check_bus(input logic [31:0] got_d, input logic got_e);
    icp_tb_exp_t e;
    if (exp_q.size() == 0) begin
      fail("bus result without expectation");
      return;
    end
    e = exp_q.pop_front();
    n_tests++;
    if (got_e !== e.err) fail("slave error flag differs");
    if (e.rd && got_d !== e.data) fail("read data differs");
  endtask

  // Decoded output field compare
  task automatic check_val(input logic [19:0] got, input logic [19:0] exp);
    n_tests++;
    if (got !== exp) fail("decoded output differs");
  endtask

  // Monitor: completed transfer at the edge where ready is sampled
  always @(posedge clk) begin
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) check_bus(prdata, pslverr);
  end

  // Hang guard, well above the expected run of about 770 cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fail("timeout");
      report_and_stop();
    end
  end

  // One full transfer; upper write bits random since only the low byte counts
  task automatic apb(input logic wr, input logic [9:0] addr, input logic [7:0] wd,
                     input logic [31:0] ed, input logic ee);
    exp_q.push_back(icp_tb_exp_t'{rd: !wr, data: ed, err: ee});
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= addr;
    pwdata  <= {24'($urandom), wd};
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    apb(1'b1, {idx, 2'b00}, d, 32'h0, 1'b0);
  endtask

  task automatic rd(input logic [7:0] idx, input logic [7:0] e);
    apb(1'b0, {idx, 2'b00}, 8'h00, {24'h0, e}, 1'b0);
  endtask

  // Outputs trail the register by one edge after the write lands
  task automatic settle();
    repeat (2) @(posedge clk);
    #1;
  endtask

  // Reference decode of mode, nominal rate and legality
  function automatic void exp_dec(input logic d, input logic l, input logic [3:0] c,
                                  input logic rs, input logic dif, output icp_mode_t m,
                                  output icp_rate_t r, output logic v);
    if (d && l) m = ICP_MODE_ALT;
    else if (d) m = ICP_MODE_PROG;
    else if (l && c != `ICP_CODE_2K && c != `ICP_CODE_4K) m = ICP_MODE_FIXED8K;
    else m = ICP_MODE_DIRECT;
    if (m == ICP_MODE_ALT) begin
      case (c)
        4'h0: r = ICP_RATE_10M;
        4'h1: r = ICP_RATE_25M;
        4'h2: r = ICP_RATE_62M5;
        4'h3: r = ICP_RATE_125M;
        4'h4: r = ICP_RATE_156M25;
        default: r = ICP_RATE_UNDEF;
      endcase
    end else begin
      case (c)
        4'h0: r = ICP_RATE_8K;
        4'h1: r = rs ? ICP_RATE_2048K : ICP_RATE_1544K;
        4'h2: r = ICP_RATE_6M48;
        4'h3: r = ICP_RATE_19M44;
        4'h4: r = ICP_RATE_25M92;
        4'h5: r = ICP_RATE_38M88;
        4'h6: r = ICP_RATE_51M84;
        4'h7: r = ICP_RATE_77M76;
        4'h8: r = ICP_RATE_155M52;
        4'h9: r = ICP_RATE_2K;
        4'hA: r = ICP_RATE_4K;
        4'hD: r = ICP_RATE_31M25;
        default: r = ICP_RATE_UNDEF;
      endcase
    end
    v = (r != ICP_RATE_UNDEF) && (dif || (r != ICP_RATE_155M52 && r != ICP_RATE_156M25))
        && !(m == ICP_MODE_FIXED8K && r == ICP_RATE_31M25);
  endfunction

  initial begin
    logic [7:0] ridx [8];
    logic [7:0] rrst [8];
    logic [4:0] ev;
    logic [1:0] b;
    logic       v;
    int         slot;
    icp_mode_t  em;
    icp_rate_t  er;
    ridx = '{`ICP_IDX_PRI_A, `ICP_IDX_PRI_B, `ICP_IDX_PRI_BACKUP, `ICP_IDX_CFG3,
             `ICP_IDX_CFG4, `ICP_IDX_CFG5, `ICP_IDX_CFG6, `ICP_IDX_CFG9};
    rrst = '{8'h32, 8'h00, 8'h04, 8'h00, 8'h00, 8'h03, 8'h03, 8'h03};
    ev = 5'h1F;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 10'h000;
    pwdata = 32'h0;
    rst_n = 1'b0;
    void'($urandom(32'h5962));
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    settle();
    // Reset values of the priority and configuration registers and the decoded priorities
    for (int i = 0; i < 8; i++) rd(ridx[i], rrst[i]);
    check_val(prio, 20'h40032);
    check_val(20'(avail), 20'h13);
    $display("test reset_values done");
    // Unused high nibble of the backup register, then a disabled input
    wr(`ICP_IDX_PRI_BACKUP, 8'hFF);
    rd(`ICP_IDX_PRI_BACKUP, 8'h0F);
    wr(`ICP_IDX_PRI_BACKUP, 8'h00);
    settle();
    check_val(20'(avail), 20'h03);
    // Forced clears from pair A writes only
    wr(`ICP_IDX_PRI_B, 8'h77);
    rd(`ICP_IDX_PRI_B, 8'h77);
    wr(`ICP_IDX_PRI_A, 8'h01);
    rd(`ICP_IDX_PRI_B, 8'h70);
    wr(`ICP_IDX_PRI_B, 8'h77);
    wr(`ICP_IDX_PRI_A, 8'h10);
    rd(`ICP_IDX_PRI_B, 8'h07);
    wr(`ICP_IDX_PRI_B, 8'h77);
    wr(`ICP_IDX_PRI_A, 8'h00);
    rd(`ICP_IDX_PRI_B, 8'h77);
    settle();
    check_val(prio, 20'h07700);
    check_val(20'(avail), 20'h0C);
    $display("test priority_clears done");
    // Target select hides priorities without losing them
    wr(`ICP_IDX_AUX, 8'h01);
    settle();
    check_val(prio, 20'h0);
    check_val(20'(avail), 20'h0);
    rd(`ICP_IDX_PRI_B, 8'h77);
    wr(`ICP_IDX_AUX, 8'h00);
    settle();
    check_val(prio, 20'h07700);
    $display("test target_select done");
    // Every mode and code on a single-ended and a differential input
    for (int s = 0; s < 2; s++) begin
      slot = 2 * s;
      wr(`ICP_IDX_AUX, {6'h0, s[0], 1'b0});
      for (int m = 0; m < 4; m++) begin
        for (int c = 0; c < 16; c++) begin
          b = 2'($urandom_range(3));
          // In programmable mode the code names the post-divider rate
          wr(s ? `ICP_IDX_CFG5 : `ICP_IDX_CFG3, {m[1:0], b, c[3:0]});
          exp_dec(m[1], m[0], c[3:0], s[0], s[0], em, er, v);
          ev[slot] = v;
          settle();
          check_val(20'(pmode[2*slot+:2]), 20'(em));
          check_val(20'(rate[5*slot+:5]), 20'(er));
          check_val(20'(rvalid[slot]), 20'(v));
          check_val(20'(bucket[2*slot+:2]), 20'(b));
        end
      end
    end
    rd(`ICP_IDX_STATUS, {3'h0, ev});
    wr(`ICP_IDX_STATUS, 8'hFF);
    rd(`ICP_IDX_STATUS, {3'h0, ev});
    $display("test rate_decode done");
    // Unmapped read and misaligned write are refused
    apb(1'b0, 10'h0C0, 8'h00, 32'h0, 1'b1);
    apb(1'b1, 10'h08D, 8'h5A, 32'h0, 1'b1);
    rd(`ICP_IDX_CFG4, 8'h00);
    $display("test refusals done");
    report_and_stop();
  end

endmodule
